/* common/sec_policy_map.svh */
// register offsets, field positions, reset values and codes for the frame security policy block
`ifndef SEC_POLICY_MAP_SVH
`define SEC_POLICY_MAP_SVH
// ======================================================================
// register byte addresses
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_VCOUNT 8'h08
// ======================================================================
// control fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_ANSWER_BIT 2
// ======================================================================
// security modes
`define MODE0 2'h0
`define MODE1 2'h1
`define MODE2 2'h2
`define MODE_RESET 2'h0
`define MODE_ILLEGAL 2'h3
// ======================================================================
// misc widths and values
`define LEN_ZERO 12'h000
`define KEY_ZERO 8'h00
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define DATA_ZERO 32'h00000000
`endif

/* common/sec_policy_pkg.sv */
// types shared by the frame security policy block
package sec_policy_pkg;
  // frame type or subtype as seen by the policy
  typedef enum logic [4:0] {
    FT_BEACON, FT_IMM_ACK, FT_BLK_ACK, FT_RTS, FT_CTS, FT_UA_REQ, FT_UA_RSP,
    FT_APP_CTRL, FT_RESV_REQ, FT_RESV_RSP, FT_PROBE, FT_PAIRWISE_KEY, FT_GROUP_KEY,
    FT_RANGE, FT_APP_CMD, FT_DATA, FT_AGG_DATA
  } frame_t;
  // protection class of a frame type
  typedef enum logic [1:0] {PROT_NEVER, PROT_ALWAYS, PROT_OPTION} prot_t;
  // violation codes reported to the management entity
  typedef enum logic [1:0] {VC_NONE, VC_INVALID_MODE, VC_UNKNOWN_KEY} vcode_t;
  // transmit request from the frame builder
  typedef struct packed {
    logic valid;
    frame_t ftype;
    logic [1:0] peer_mode;
    logic related;
    logic want_secure;
    logic [7:0] temporal_key_selector;
    logic [7:0] relationship_key;
    logic [11:0] payload_len;
    logic [11:0] agg_hdr_len;
    logic [11:0] var_offset;
  } tx_req_t;
  // received frame summary from the receive path
  typedef struct packed {
    logic valid;
    frame_t ftype;
    logic secure;
    logic related;
  } rx_frame_t;
  // secure relationship request
  typedef struct packed {
    logic valid;
    logic [1:0] peer_mode;
  } rel_req_t;
endpackage

/* hdl/sec_policy.sv */
// frame security policy: transmit protection, receive filtering and relationship gating
`timescale 1ns/100ps
`include "sec_policy_map.svh"

// Notes on behaviour
// - related peers use the protection tables
// - drop unprotected frames that need protection
// - data frames use the service key selector
// - secure commands use the relationship key
// - beacon, acks, rts, cts, access frames plain
// - group key and data always protected
// - other commands and application frames optional
// - key command frames use offset zero
// - reservation and range offset equals payload
// - aggregated offset header length; others variable
// - mode 0 sends plain, no relationships
// - mode 0 secure receive: invalid mode
// - mode 1 plain to unrelated peers
// - mode 1 relates only with mode 1
// - mode 1 may answer unrelated commands
// - mode 1 unrelated secure: unknown key
// - mode 1 related plain required: invalid mode
// - reset never in mode 1
// - mode 2 relates mode 2, handshake first
// - mode 2 tables toward related peers
// - mode 2 unrelated secure: unknown key
// - mode 2 plain required: invalid mode
// - beacons advertise the current mode
module sec_policy
  import sec_policy_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire tx_req_t tx_req,
  output logic tx_valid_r,
  output logic tx_secure_r,
  output logic tx_blocked_r,
  output logic [11:0] encryption_offset_r,
  output logic [7:0] tx_key_r,
  input wire rx_frame_t rx_frame,
  output logic rx_accept_r,
  output logic rx_discard_r,
  output logic rx_respond_r,
  output logic security_violation_report_r,
  output vcode_t violation_code_r,
  input wire rel_req_t rel_req,
  output logic rel_permit_r,
  output logic rel_refuse_r,
  output logic [1:0] beacon_mode_r
);

  // ======================================================================
  // state
  logic [1:0] mode_r;
  logic answer_unrelated_r;
  logic [15:0] inval_cnt_r;
  logic [15:0] unkey_cnt_r;
  logic [31:0] dat_r;
  logic ack_r;
  frame_t tx_ftype_r;
  logic req;
  logic wr_ctrl;
  logic wr_vcount;

  // protection class per frame type
  function automatic prot_t prot_class(input frame_t ft);
    prot_t p;
    p = PROT_OPTION;
    unique case (ft)
      FT_BEACON, FT_IMM_ACK, FT_BLK_ACK, FT_RTS, FT_CTS, FT_UA_REQ, FT_UA_RSP: p = PROT_NEVER;
      FT_GROUP_KEY, FT_DATA, FT_AGG_DATA: p = PROT_ALWAYS;
      FT_APP_CTRL, FT_RESV_REQ, FT_RESV_RSP, FT_PROBE, FT_PAIRWISE_KEY, FT_RANGE, FT_APP_CMD: p = PROT_OPTION;
      default: p = PROT_OPTION;
    endcase
    return p;
  endfunction

  // command frames (for the answer policy)
  function automatic logic is_command(input frame_t ft);
    return ft inside {FT_RESV_REQ, FT_RESV_RSP, FT_PROBE, FT_PAIRWISE_KEY, FT_GROUP_KEY, FT_RANGE, FT_APP_CMD};
  endfunction

  // ======================================================================
  // wishbone classic slave
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_ctrl = req & ack_r & wb_we_i & wb_sel_i[0] & (wb_adr_i == `REG_CTRL);
  assign wr_vcount = req & ack_r & wb_we_i & (wb_adr_i == `REG_VCOUNT);
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // read data captured with the request, zero for unmapped
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dat_r <= `DATA_ZERO;
    end else if (req & ~ack_r) begin
      unique case (wb_adr_i)
        `REG_CTRL: dat_r <= {29'h0, answer_unrelated_r, mode_r};
        `REG_STATUS: dat_r <= {28'h0, violation_code_r, mode_r};
        `REG_VCOUNT: dat_r <= {unkey_cnt_r, inval_cnt_r};
        default: dat_r <= `DATA_ZERO;
      endcase
    end
  end

  // mode register; resets to mode 0, changes only by software, illegal code ignored
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_r <= `MODE_RESET;
      answer_unrelated_r <= 1'b0;
    end else if (wr_ctrl) begin
      if (wb_dat_i[`CTRL_MODE_MSB:`CTRL_MODE_LSB] != `MODE_ILLEGAL) begin
        mode_r <= wb_dat_i[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
      end
      answer_unrelated_r <= wb_dat_i[`CTRL_ANSWER_BIT];
    end
  end

  // violation counters; a write clears, a same-cycle event restarts the count at one
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      inval_cnt_r <= `CNT_ZERO;
      unkey_cnt_r <= `CNT_ZERO;
    end else begin
      if (security_violation_report_r && violation_code_r == VC_INVALID_MODE) begin
        inval_cnt_r <= wr_vcount ? `CNT_ONE : inval_cnt_r + `CNT_ONE;
      end else if (wr_vcount) begin
        inval_cnt_r <= `CNT_ZERO;
      end
      if (security_violation_report_r && violation_code_r == VC_UNKNOWN_KEY) begin
        unkey_cnt_r <= wr_vcount ? `CNT_ONE : unkey_cnt_r + `CNT_ONE;
      end else if (wr_vcount) begin
        unkey_cnt_r <= `CNT_ZERO;
      end
    end
  end

  // ======================================================================
  // transmit decision
  logic tx_tables;
  logic tx_sec;
  logic tx_block;
  logic [11:0] tx_off;
  logic [7:0] tx_key;

  // tables apply only to a related peer in the same non-zero mode
  always_comb begin
    tx_tables = tx_req.related && mode_r != `MODE0 && tx_req.peer_mode == mode_r;
    tx_sec = 1'b0;
    if (tx_tables) begin
      unique case (prot_class(tx_req.ftype))
        PROT_NEVER: tx_sec = 1'b0;
        PROT_ALWAYS: tx_sec = 1'b1;
        PROT_OPTION: tx_sec = tx_req.want_secure;
      endcase
    end
    // mode 2 sends no data before the handshake gives a relationship
    tx_block = mode_r == `MODE2 && !tx_tables && tx_req.ftype inside {FT_DATA, FT_AGG_DATA};
    tx_off = `LEN_ZERO;
    tx_key = `KEY_ZERO;
    if (tx_sec) begin
      unique case (tx_req.ftype)
        FT_PAIRWISE_KEY, FT_GROUP_KEY: tx_off = `LEN_ZERO;
        FT_RESV_REQ, FT_RESV_RSP, FT_RANGE: tx_off = tx_req.payload_len;
        FT_AGG_DATA: tx_off = tx_req.agg_hdr_len;
        default: tx_off = tx_req.var_offset;
      endcase
      if (tx_req.ftype inside {FT_DATA, FT_AGG_DATA}) begin
        tx_key = tx_req.temporal_key_selector;
      end else begin
        tx_key = tx_req.relationship_key;
      end
    end
  end

  // registered transmit answer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_valid_r <= 1'b0;
      tx_secure_r <= 1'b0;
      tx_blocked_r <= 1'b0;
      encryption_offset_r <= `LEN_ZERO;
      tx_key_r <= `KEY_ZERO;
      tx_ftype_r <= FT_BEACON;
    end else begin
      tx_valid_r <= tx_req.valid & ~tx_block;
      tx_blocked_r <= tx_req.valid & tx_block;
      tx_secure_r <= tx_req.valid & ~tx_block & tx_sec;
      encryption_offset_r <= tx_off;
      tx_key_r <= tx_key;
      tx_ftype_r <= tx_req.ftype;
    end
  end

  // ======================================================================
  // receive filter
  vcode_t rx_code;
  logic rx_need;

  // classify the received frame against the current mode
  always_comb begin
    rx_need = prot_class(rx_frame.ftype) == PROT_ALWAYS;
    rx_code = VC_NONE;
    unique case (mode_r)
      `MODE0: begin
        if (rx_frame.secure) rx_code = VC_INVALID_MODE;
      end
      `MODE1: begin
        if (rx_frame.secure && !rx_frame.related) rx_code = VC_UNKNOWN_KEY;
        else if (!rx_frame.secure && rx_frame.related && rx_need) rx_code = VC_INVALID_MODE;
      end
      `MODE2: begin
        if (rx_frame.secure && !rx_frame.related) rx_code = VC_UNKNOWN_KEY;
        else if (!rx_frame.secure && rx_need) rx_code = VC_INVALID_MODE;
      end
      default: rx_code = VC_NONE;
    endcase
  end

  // registered receive answer and violation strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_accept_r <= 1'b0;
      rx_discard_r <= 1'b0;
      rx_respond_r <= 1'b0;
      security_violation_report_r <= 1'b0;
      violation_code_r <= VC_NONE;
    end else begin
      rx_accept_r <= rx_frame.valid && rx_code == VC_NONE;
      rx_discard_r <= rx_frame.valid && rx_code != VC_NONE;
      security_violation_report_r <= rx_frame.valid && rx_code != VC_NONE;
      if (rx_frame.valid && rx_code != VC_NONE) begin
        violation_code_r <= rx_code;
      end
      // answering unrelated commands in mode 1 is software's choice
      rx_respond_r <= rx_frame.valid && rx_code == VC_NONE && is_command(rx_frame.ftype) &&
                      (rx_frame.related || mode_r != `MODE1 || answer_unrelated_r);
    end
  end

  // ======================================================================
  // relationship gate and beacon mode
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rel_permit_r <= 1'b0;
      rel_refuse_r <= 1'b0;
      beacon_mode_r <= `MODE_RESET;
    end else begin
      rel_permit_r <= rel_req.valid && mode_r != `MODE0 && rel_req.peer_mode == mode_r;
      rel_refuse_r <= rel_req.valid && !(mode_r != `MODE0 && rel_req.peer_mode == mode_r);
      beacon_mode_r <= mode_r;
    end
  end

  // ======================================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  mode0_tx_plain_a: assert property ($past(mode_r) == `MODE0 |-> !tx_secure_r)
    else $error("secure frame sent in mode 0");
  never_secure_a: assert property (tx_valid_r && prot_class(tx_ftype_r) == PROT_NEVER |-> !tx_secure_r)
    else $error("never-protected frame sent secure");
  always_secure_a: assert property (tx_req.valid && tx_req.related && mode_r != `MODE0 &&
      tx_req.peer_mode == mode_r && prot_class(tx_req.ftype) == PROT_ALWAYS |=> tx_valid_r && tx_secure_r)
    else $error("always-protected frame sent plain");
  key_offset_a: assert property (tx_secure_r && tx_ftype_r inside {FT_PAIRWISE_KEY, FT_GROUP_KEY}
      |-> encryption_offset_r == `LEN_ZERO)
    else $error("key command offset not zero");
  mode0_rx_drop_a: assert property (rx_frame.valid && rx_frame.secure && mode_r == `MODE0
      |=> rx_discard_r && security_violation_report_r && violation_code_r == VC_INVALID_MODE)
    else $error("mode 0 secure frame not rejected");
  unknown_key_a: assert property (rx_frame.valid && rx_frame.secure && !rx_frame.related &&
      mode_r != `MODE0 |=> rx_discard_r && violation_code_r == VC_UNKNOWN_KEY && !rx_accept_r)
    else $error("unrelated secure frame not rejected");
  mode2_plain_a: assert property (rx_frame.valid && !rx_frame.secure && mode_r == `MODE2 &&
      rx_frame.ftype inside {FT_DATA, FT_AGG_DATA, FT_GROUP_KEY} |=> rx_discard_r && violation_code_r == VC_INVALID_MODE)
    else $error("mode 2 plain data not rejected");
  strobe_cause_a: assert property (security_violation_report_r |-> rx_discard_r && $past(rx_frame.valid))
    else $error("violation strobe without a discarded frame");
  mode_write_a: assert property ($changed(mode_r) |-> $past(wr_ctrl))
    else $error("mode changed without a control write");
  rel_gate_a: assert property (rel_permit_r |-> $past(rel_req.peer_mode) == $past(mode_r) &&
      $past(mode_r) != `MODE0)
    else $error("relationship permitted across modes");

  // ======================================================================
  // transmit, receive and control checks
  // a plain frame carries neither offset nor key
  plain_fields_a: assert property (tx_valid_r && !tx_secure_r
      |-> encryption_offset_r == `LEN_ZERO && tx_key_r == `KEY_ZERO)
    else $error("plain frame carries an offset or key");
  // mode 1 sends plain unless the peer is a related mode 1 device
  mode1_plain_tx_a: assert property (tx_req.valid && mode_r == `MODE1 &&
      !(tx_req.related && tx_req.peer_mode == `MODE1) |=> tx_valid_r && !tx_secure_r)
    else $error("mode 1 frame to unrelated peer sent secure");
  // data frames take the key selector handed in with them
  data_key_a: assert property (tx_secure_r && tx_ftype_r inside {FT_DATA, FT_AGG_DATA}
      |-> tx_key_r == $past(tx_req.temporal_key_selector))
    else $error("data frame key is not the service key selector");
  // secure commands and control frames take the relationship key
  cmd_key_a: assert property (tx_secure_r && !(tx_ftype_r inside {FT_DATA, FT_AGG_DATA})
      |-> tx_key_r == $past(tx_req.relationship_key))
    else $error("command frame key is not the relationship key");
  // reservation and range frames leave the payload unencrypted
  payload_offset_a: assert property (tx_secure_r && tx_ftype_r inside {FT_RESV_REQ, FT_RESV_RSP, FT_RANGE}
      |-> encryption_offset_r == $past(tx_req.payload_len))
    else $error("reservation or range offset not the payload length");
  // aggregated data skips its header and pad
  agg_offset_a: assert property (tx_secure_r && tx_ftype_r == FT_AGG_DATA
      |-> encryption_offset_r == $past(tx_req.agg_hdr_len))
    else $error("aggregated data offset not the header length");
  // probe, data and application frames take the variable offset
  var_offset_a: assert property (tx_secure_r && tx_ftype_r inside {FT_PROBE, FT_DATA, FT_APP_CMD}
      |-> encryption_offset_r == $past(tx_req.var_offset))
    else $error("probe, data or application offset not the variable offset");
  // mode 2 holds data back until a relationship exists
  data_block_a: assert property (tx_req.valid && mode_r == `MODE2 && !(tx_req.related &&
      tx_req.peer_mode == `MODE2) && tx_req.ftype inside {FT_DATA, FT_AGG_DATA} |=> tx_blocked_r && !tx_valid_r)
    else $error("mode 2 data sent without a relationship");
  // mode 2 protects group key frames toward related mode 2 peers
  mode2_tables_a: assert property (tx_req.valid && mode_r == `MODE2 && tx_req.related &&
      tx_req.peer_mode == `MODE2 && tx_req.ftype == FT_GROUP_KEY |=> tx_valid_r && tx_secure_r)
    else $error("mode 2 group key frame sent plain");
  // mode 1 drops a plain frame from a related peer that needs protection
  mode1_plain_rx_a: assert property (rx_frame.valid && !rx_frame.secure && rx_frame.related &&
      mode_r == `MODE1 && prot_class(rx_frame.ftype) == PROT_ALWAYS
      |=> rx_discard_r && violation_code_r == VC_INVALID_MODE)
    else $error("mode 1 related plain frame not rejected");
  // mode 2 reports a secure frame from an unrelated peer as unknown key
  mode2_unknown_a: assert property (rx_frame.valid && rx_frame.secure && !rx_frame.related &&
      mode_r == `MODE2 |=> security_violation_report_r && violation_code_r == VC_UNKNOWN_KEY)
    else $error("mode 2 unrelated secure frame not reported");
  // every received frame is either accepted or discarded
  one_verdict_a: assert property (rx_frame.valid |=> rx_accept_r != rx_discard_r)
    else $error("received frame both or neither accepted and discarded");
  // mode 1 stays silent to unrelated commands unless software allows it
  quiet_unrelated_a: assert property (rx_frame.valid && mode_r == `MODE1 && !rx_frame.related &&
      !answer_unrelated_r |=> !rx_respond_r)
    else $error("unrelated command answered against the setting");
  // beacons carry the mode selected one cycle earlier
  beacon_mode_a: assert property (beacon_mode_r == $past(mode_r))
    else $error("beacon mode differs from the selected mode");
  // the block leaves reset in the default mode, never mode 1
  reset_mode_a: assert property ($rose(resetn) |-> mode_r == `MODE_RESET)
    else $error("mode after reset is not the default");
  // an illegal mode code leaves the mode as it was
  illegal_mode_a: assert property (wr_ctrl && wb_dat_i[`CTRL_MODE_MSB:`CTRL_MODE_LSB] == `MODE_ILLEGAL
      |=> $stable(mode_r))
    else $error("illegal mode code was taken");
  // mode 0 never grants a relationship
  mode0_no_rel_a: assert property (rel_req.valid && mode_r == `MODE0 |=> rel_refuse_r && !rel_permit_r)
    else $error("relationship granted in mode 0");
  // mode 2 refuses relationships with mode 0 and mode 1 peers
  mode2_refuse_a: assert property (rel_req.valid && mode_r == `MODE2 && rel_req.peer_mode != `MODE2
      |=> rel_refuse_r && !rel_permit_r)
    else $error("mode 2 accepted a relationship with another mode");
  // acknowledge is a single-cycle pulse
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held longer than one cycle");

endmodule

/* testbench/peer_model.sv */
// peer device model presenting received frame summaries to the policy block
`timescale 1ns/100ps
module peer_model
  import sec_policy_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic go,
  input wire frame_t ftype,
  input wire logic secure,
  input wire logic related,
  output rx_frame_t rx_frame
);
  // ======================================================================
  // frame presentation
  // protection is sent as commanded; a breach only when the bench asks
  // outside frames the fields flip so no stale value looks valid
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_frame <= '0;
    end else if (go) begin
      rx_frame <= {1'b1, ftype, secure, related};
    end else begin
      rx_frame <= {1'b0, ~rx_frame[6:0]};
    end
  end
endmodule

/* testbench/sec_policy_tb.sv */
// self-checking bench for the frame security policy block
`timescale 1ns/100ps
`include "sec_policy_map.svh"
module sec_policy_tb
  import sec_policy_pkg::*;
;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  tx_req_t tx_req = '0;
  rel_req_t rel_req = '0;
  rx_frame_t rx_frame;
  logic go = 1'b0, psec = 1'b0, prel = 1'b0;
  frame_t pft = FT_BEACON;
  logic tx_valid_r, tx_secure_r, tx_blocked_r, rx_accept_r, rx_discard_r, rx_respond_r;
  logic security_violation_report_r, rel_permit_r, rel_refuse_r;
  logic [11:0] encryption_offset_r;
  logic [7:0] tx_key_r;
  logic [1:0] beacon_mode_r, mode, last_code;
  vcode_t violation_code_r;
  logic ans;
  int errors = 0, cmp_count = 0;
  logic [15:0] n_inv = 16'h0, n_unk = 16'h0;
  logic [31:0] seed = 32'h757543AD;
  logic [22:0] tx_q[$];
  logic [5:0] rx_q[$];
  logic [1:0] rel_q[$];
  logic [2:0] ctrl [5] = '{3'h0, 3'h1, 3'h5, 3'h3, 3'h2};

  sec_policy i_sec_policy (.clock, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .tx_req, .tx_valid_r, .tx_secure_r, .tx_blocked_r, .encryption_offset_r, .tx_key_r,
    .rx_frame, .rx_accept_r, .rx_discard_r, .rx_respond_r, .security_violation_report_r, .violation_code_r,
    .rel_req, .rel_permit_r, .rel_refuse_r, .beacon_mode_r);
  peer_model i_peer_model (.clock, .resetn, .go, .ftype(pft), .secure(psec), .related(prel), .rx_frame);

  // clock
  initial begin
    forever #2 clock = ~clock;
  end

  // ======================================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic prot_t cls(input frame_t f);
    if (f <= FT_UA_RSP) return PROT_NEVER;
    if (f inside {FT_GROUP_KEY, FT_DATA, FT_AGG_DATA}) return PROT_ALWAYS;
    return PROT_OPTION;
  endfunction
  task automatic tally_and_finish();
    errors += tx_q.size() + rx_q.size() + rel_q.size();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_reg(input logic [31:0] e, input logic [31:0] g); cmp(e, g); endtask
  task automatic cmp_tx(input logic [22:0] e, input logic [22:0] g); cmp({9'h0, e}, {9'h0, g}); endtask
  task automatic cmp_rx(input logic [5:0] e, input logic [5:0] g); cmp({26'h0, e}, {26'h0, g}); endtask
  task automatic cmp_rel(input logic [1:0] e, input logic [1:0] g); cmp({30'h0, e}, {30'h0, g}); endtask

  // ======================================================================
  // drivers: the frame and relationship senders note their expected result before launching the request
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    cmp_reg(e, r);
  endtask
  task automatic tx_send(input frame_t f, input logic r, input logic [1:0] pm);
    tx_req_t t;
    logic s;
    logic [11:0] off;
    logic [7:0] key;
    seed = lfsr(seed);
    t = {1'b1, f, pm, r, seed[0], seed[31:24], seed[23:16], seed[11:0], seed[23:12], seed[27:16]};
    s = r && pm == mode && mode != `MODE0 && (cls(f) == PROT_ALWAYS || (cls(f) == PROT_OPTION && t.want_secure));
    off = f inside {FT_RESV_REQ, FT_RESV_RSP, FT_RANGE} ? t.payload_len : t.var_offset;
    off = !s || f inside {FT_PAIRWISE_KEY, FT_GROUP_KEY} ? 12'h000 : f == FT_AGG_DATA ? t.agg_hdr_len : off;
    key = !s ? 8'h00 : f inside {FT_DATA, FT_AGG_DATA} ? t.temporal_key_selector : t.relationship_key;
    if (mode == `MODE2 && !(r && pm == `MODE2) && f inside {FT_DATA, FT_AGG_DATA}) tx_q.push_back({3'b001, 20'h0});
    else tx_q.push_back({1'b1, s, 1'b0, off, key});
    @(posedge clock);
    tx_req <= t;
  endtask
  task automatic rx_send(input frame_t f, input logic s, input logic r);
    logic [1:0] c;
    logic d;
    c = (mode == `MODE0 && s) ? VC_INVALID_MODE : (s && !r) ? VC_UNKNOWN_KEY : VC_NONE;
    if (!s && cls(f) == PROT_ALWAYS && (mode == `MODE2 || (mode == `MODE1 && r))) c = VC_INVALID_MODE;
    d = c != VC_NONE;
    n_inv += 16'(c == VC_INVALID_MODE);
    n_unk += 16'(c == VC_UNKNOWN_KEY);
    if (d) last_code = c;
    rx_q.push_back({!d, d, !d && f inside {[FT_RESV_REQ:FT_APP_CMD]} && (mode != `MODE1 || r || ans), d, c});
    @(posedge clock);
    go <= 1'b1;
    pft <= f;
    psec <= s;
    prel <= r;
  endtask
  task automatic rel_send(input logic [1:0] pm);
    logic p;
    p = mode != `MODE0 && pm == mode;
    rel_q.push_back({p, !p});
    @(posedge clock);
    rel_req <= {1'b1, pm};
  endtask
  task automatic idle();
    @(posedge clock);
    tx_req.valid <= 1'b0;
    rel_req.valid <= 1'b0;
    go <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  // ======================================================================
  // watcher: takes the oldest note whenever a result appears
  always @(negedge clock) begin
    if (resetn) begin
      if (tx_valid_r === 1'b1 || tx_blocked_r === 1'b1)
        cmp_tx(tx_q.size() ? tx_q.pop_front() : 'x, {tx_valid_r, tx_secure_r, tx_blocked_r, encryption_offset_r,
          tx_key_r});
      if (rx_accept_r === 1'b1 || rx_discard_r === 1'b1)
        cmp_rx(rx_q.size() ? rx_q.pop_front() : 'x, {rx_accept_r, rx_discard_r, rx_respond_r,
          security_violation_report_r, rx_discard_r ? violation_code_r : VC_NONE});
      if (rel_permit_r === 1'b1 || rel_refuse_r === 1'b1)
        cmp_rel(rel_q.size() ? rel_q.pop_front() : 'x, {rel_permit_r, rel_refuse_r});
    end
  end

  // ======================================================================
  // main sequence: every mode, every frame type, both protections and relations
  initial begin
    mode = `MODE0;
    ans = 1'b0;
    last_code = VC_NONE;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    rd(`REG_CTRL, 32'h0);
    rd(`REG_VCOUNT, 32'h0);
    for (int p = 0; p < 5; p++) begin
      wb(1'b1, `REG_CTRL, {29'h0, ctrl[p]}, q);
      if (ctrl[p][1:0] != 2'h3) mode = ctrl[p][1:0];
      ans = ctrl[p][2];
      rd(`REG_CTRL, {29'h0, ans, mode});
      cmp_reg({30'h0, mode}, {30'h0, beacon_mode_r});
      for (int k = 0; k < 68; k++) tx_send(frame_t'(k >> 2), k[0], (k[1] && mode != `MODE2) ? `MODE0 : mode);
      idle();
      for (int k = 0; k < 68; k++) rx_send(frame_t'(k >> 2), k[0], k[1]);
      idle();
      for (int k = 0; k < 3; k++) rel_send(k[1:0]);
      idle();
      rd(`REG_STATUS, {28'h0, last_code, mode});
    end
    rd(`REG_VCOUNT, {n_unk, n_inv});
    wb(1'b1, `REG_VCOUNT, 32'h0, q);
    rd(`REG_VCOUNT, 32'h0);
    wb(1'b1, 8'h0C, 32'h1, q);
    wb(1'b1, `REG_STATUS, 32'h1, q);
    rd(8'h0C, 32'h0);
    rd(`REG_STATUS, {28'h0, last_code, mode});
    tally_and_finish();
  end
endmodule
